/* design/froe_defines.vh */
// Purpose: Constants for the file-register operation execute block.
// Assumes: 14-bit instruction words, 8-bit data path.
// Notes: Included by both design files.
`ifndef FROE_DEFINES_VH
`define FROE_DEFINES_VH
// ****************************************
// Opcode fields
// ****************************************
`define FROE_OP_SUM 6'h07
`define FROE_OP_MASK 6'h05
`define FROE_OP_BITCLR 4'h4
`define FROE_OP_BITTST 4'h6
`define FROE_D_BIT 7
`define FROE_NOP_WORD 14'h0000
// ****************************************
// Status flag positions
// ****************************************
`define FROE_FLAG_C 0
`define FROE_FLAG_NIBBLE 1
`define FROE_FLAG_Z 2
// ****************************************
// Phases, reset values and timer count address
// ****************************************
`define FROE_Q1 2'h0
`define FROE_Q2 2'h1
`define FROE_Q3 2'h2
`define FROE_Q4 2'h3
`define FROE_ACC_RESET 8'h00
`define FROE_TIMER_COUNT_ADDR 7'h01
`endif

/* design/froe_alu.v */
// Purpose: Arithmetic and bit logic for the execute block.
// Assumes: Operands are stable during the process phase.
// Notes: Purely combinational.
`timescale 1ns/10ps
`include "froe_defines.vh"
module froe_alu (
	// Operation select
	input wire [1:0] op_sel,
	input wire [2:0] bit_pos,
	// Operands
	input wire [7:0] acc,
	input wire [7:0] operand,
	// Results
	output reg [7:0] result,
	output reg carry,
	output reg nibble_carry,
	output wire zero,
	output wire tested_bit
);
	reg [4:0] low_sum;
	reg [8:0] full_sum;
	assign zero = (result == 8'h00);
	assign tested_bit = operand[bit_pos];
	always @*
	begin
		low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
		full_sum = {1'b0, acc} + {1'b0, operand};
		carry = full_sum[8];
		nibble_carry = low_sum[4];
		case (op_sel)
			2'h0: result = full_sum[7:0];
			2'h1: result = acc & operand;
			2'h2: result = operand & ~(8'h01 << bit_pos);
			default: result = operand;
		endcase
	end
endmodule // froe_alu

/* design/froe_exec.v */
// Purpose: Executes add, AND, bit-clear and test-skip file operations.
// Assumes: One new instruction word is presented per instruction cycle.
// Notes: Each instruction cycle is four clocks, one per phase.
//
// Summary of operation
// - Decode add, update carry, nibble, zero.
// - Select bit zero to accumulator, one to file.
// - Decode AND, update zero flag only.
// - Bit clear forces one bit low, no flags.
// - Test bit set executes next instruction normally.
// - Test bit clear discards next, runs no-op.
// - Single cycle: decode, read, process, write.
// - Test writes nothing; skip cycle all no-ops.
// - Port operands come from pins, not latch.
// - Timer count write clears assigned prescaler.
`timescale 1ns/10ps
`include "froe_defines.vh"
module froe_exec (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Instruction stream
	input wire [13:0] instr,
	// File register read port
	input wire [7:0] file_rdata,
	input wire [7:0] port_pin_data,
	input wire file_is_port,
	input wire prescaler_to_timer,
	// File register write port
	output reg [6:0] file_addr,
	output reg file_rd,
	output reg file_we,
	output reg [7:0] file_wdata,
	output reg prescaler_clear,
	// Core state
	output reg [7:0] acc,
	output reg [2:0] status_flags,
	output reg [1:0] phase,
	output reg skip_cycle,
	output reg instr_done
);
	// ****************************************
	// Decode
	// ****************************************
	localparam OP_NONE = 3'h0;
	localparam OP_SUM = 3'h1;
	localparam OP_MASK = 3'h2;
	localparam OP_CLR = 3'h3;
	localparam OP_TST = 3'h4;
	reg [13:0] ir;
	reg [2:0] op;
	reg [7:0] operand;
	reg [7:0] res;
	reg res_c;
	reg res_nibble;
	reg res_z;
	reg skip_pending;
	wire [7:0] alu_result;
	wire alu_c;
	wire alu_nibble;
	wire alu_z;
	wire alu_bit;
	wire [2:0] next_op;
	wire dest_file;
	function [2:0] decode_op;
		input [13:0] w;
		begin
			if (w[13:8] == `FROE_OP_SUM)
				decode_op = OP_SUM;
			else if (w[13:8] == `FROE_OP_MASK)
				decode_op = OP_MASK;
			else if (w[13:10] == `FROE_OP_BITCLR)
				decode_op = OP_CLR;
			else if (w[13:10] == `FROE_OP_BITTST)
				decode_op = OP_TST;
			else
				decode_op = OP_NONE;
		end
	endfunction
	assign next_op = decode_op(instr);
	assign dest_file = ir[`FROE_D_BIT];
	froe_alu u_alu (
		.op_sel((op == OP_SUM) ? 2'h0 : (op == OP_MASK) ? 2'h1 :
			(op == OP_CLR) ? 2'h2 : 2'h3),
		.bit_pos(ir[9:7]),
		.acc(acc),
		.operand(operand),
		.result(alu_result),
		.carry(alu_c),
		.nibble_carry(alu_nibble),
		.zero(alu_z),
		.tested_bit(alu_bit)
	);
	// ****************************************
	// Four-phase sequencing
	// ****************************************
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			phase <= `FROE_Q1;
			ir <= `FROE_NOP_WORD;
			op <= OP_NONE;
			operand <= 8'h00;
			res <= 8'h00;
			res_c <= 1'b0;
			res_nibble <= 1'b0;
			res_z <= 1'b0;
			skip_pending <= 1'b0;
			skip_cycle <= 1'b0;
			acc <= `FROE_ACC_RESET;
			status_flags <= 3'h0;
			file_addr <= 7'h00;
			file_rd <= 1'b0;
			file_we <= 1'b0;
			file_wdata <= 8'h00;
			prescaler_clear <= 1'b0;
			instr_done <= 1'b0;
		end
		else
		begin
			phase <= phase + 2'h1;
			file_rd <= 1'b0;
			file_we <= 1'b0;
			prescaler_clear <= 1'b0;
			instr_done <= 1'b0;
			case (phase)
				`FROE_Q1:
				begin
					skip_cycle <= skip_pending;
					skip_pending <= 1'b0;
					if (skip_pending)
					begin
						ir <= `FROE_NOP_WORD;
						op <= OP_NONE;
					end
					else
					begin
						ir <= instr;
						op <= next_op;
						file_addr <= instr[6:0];
						file_rd <= (next_op != OP_NONE);
					end
				end
				`FROE_Q2:
				begin
					operand <= file_is_port ? port_pin_data : file_rdata;
				end
				`FROE_Q3:
				begin
					res <= alu_result;
					res_c <= alu_c;
					res_nibble <= alu_nibble;
					res_z <= alu_z;
					if (op == OP_TST)
						skip_pending <= ~alu_bit;
				end
				default:
				begin
					instr_done <= 1'b1;
					case (op)
						OP_SUM, OP_MASK:
						begin
							if (dest_file)
							begin
								file_we <= 1'b1;
								file_wdata <= res;
								prescaler_clear <= prescaler_to_timer &&
									(file_addr == `FROE_TIMER_COUNT_ADDR);
							end
							else
								acc <= res;
							status_flags[`FROE_FLAG_Z] <= res_z;
							if (op == OP_SUM)
							begin
								status_flags[`FROE_FLAG_C] <= res_c;
								status_flags[`FROE_FLAG_NIBBLE] <= res_nibble;
							end
						end
						OP_CLR:
						begin
							file_we <= 1'b1;
							file_wdata <= res;
							prescaler_clear <= prescaler_to_timer &&
								(file_addr == `FROE_TIMER_COUNT_ADDR);
						end
						default:
						begin
							file_we <= 1'b0;
						end
					endcase
				end
			endcase
		end
	end
endmodule // froe_exec

/* sim/froe_exec_assertions.sv */
// Purpose: Port checker for froe_exec.
// Assumes: Bound to every froe_exec instance.
// Notes: One clock domain.
`timescale 1ns/10ps
module froe_exec_assertions (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Watched ports
	input wire [13:0] instr,
	input wire [6:0] file_addr,
	input wire file_rd,
	input wire file_we,
	input wire [7:0] file_wdata,
	input wire prescaler_clear,
	input wire [7:0] acc,
	input wire [2:0] status_flags,
	input wire [1:0] phase,
	input wire skip_cycle
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_phase_wrap: assert property (phase == 2'h3 |=> phase == 2'h0)
		else $error("phase wrap");
	a_read_phase: assert property (file_rd |-> phase == 2'h1)
		else $error("read phase");
	a_write_phase: assert property (file_we |-> phase == 2'h0)
		else $error("write phase");
	a_write_source: assert property (file_we |-> $past(instr[13:10], 4) == 4'h4
		|| $past(instr[13:12], 4) == 2'h0 && $past(instr[7], 4)) else $error("write source");
	a_clear_bit: assert property (file_we && $past(instr[13:10], 4) == 4'h4
		|-> !file_wdata[$past(instr[9:7], 4)]) else $error("clear bit");
	a_timer_clear: assert property (prescaler_clear |-> file_we && file_addr == 7'h01)
		else $error("timer clear");
	a_core_hold: assert property (phase != 2'h0 |-> $stable(acc) && $stable(status_flags))
		else $error("core hold");
	a_skip_length: assert property ($rose(skip_cycle) |-> skip_cycle [*4] ##1 !skip_cycle)
		else $error("skip length");
	a_skip_quiet: assert property (skip_cycle |-> !file_we && !file_rd)
		else $error("skip quiet");
	c_skip: cover property ($rose(skip_cycle));
	c_timer: cover property (prescaler_clear);
	c_write: cover property (file_we);
endmodule // froe_exec_assertions
bind froe_exec froe_exec_assertions chk (.clk(clk), .reset_n(reset_n), .instr(instr),
	.file_addr(file_addr), .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
	.prescaler_clear(prescaler_clear), .acc(acc), .status_flags(status_flags),
	.phase(phase), .skip_cycle(skip_cycle));

/* sim/file_register_op_execute_test.sv */
// Purpose: Self-checking bench for froe_exec.
// Assumes: One word is offered every four clocks.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module file_register_op_execute_test;
	// ****
	// Bench
	// ****
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg [13:0] instr = 14'h0000;
	reg [7:0] file_rdata = 8'h00;
	reg [7:0] port_pin_data = 8'h00;
	reg file_is_port = 1'b0;
	reg prescaler_to_timer = 1'b1;
	reg skip, rd_seen;
	wire [6:0] file_addr;
	wire [7:0] file_wdata, acc;
	wire [2:0] status_flags;
	wire [1:0] phase;
	wire file_rd, file_we, prescaler_clear, skip_cycle, instr_done;
	integer num_errors = 0;
	integer compares = 0;
	always #5 clk = ~clk;
	froe_exec dut (.clk(clk), .reset_n(reset_n), .instr(instr), .file_rdata(file_rdata),
		.port_pin_data(port_pin_data), .file_is_port(file_is_port),
		.prescaler_to_timer(prescaler_to_timer),
		.file_addr(file_addr), .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
		.prescaler_clear(prescaler_clear), .acc(acc), .status_flags(status_flags),
		.phase(phase), .skip_cycle(skip_cycle), .instr_done(instr_done));
	task test_done;
	begin
		$display("Errors %0d of %0d compares", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk(input [39:0] name, input [7:0] got, input [7:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("Error %0s expected %h seen %h", name, exp, got);
		end
	end
	endtask
	task op(input [13:0] w, input [7:0] rd, input [7:0] pins, input port);
	begin
		instr = w;
		file_rdata = rd;
		port_pin_data = pins;
		file_is_port = port;
		skip = 1'b0;
		rd_seen = 1'b0;
		repeat (4)
		begin
			@(posedge clk);
			#1 skip = skip | skip_cycle;
			rd_seen = rd_seen | file_rd;
		end
		chk("done", instr_done, 8'h01);
		chk("phase", phase, 8'h00);
	end
	endtask
	task s_sum;
	begin
		op(14'h0710, 8'h17, 8'h00, 1'b0);
		chk("acc", acc, 8'h17);
		chk("rd", rd_seen, 8'h01);
		chk("addr", file_addr, 8'h10);
		op(14'h0790, 8'hF9, 8'h00, 1'b0);
		chk("wdata", file_wdata, 8'h10);
		chk("acc", acc, 8'h17);
		chk("flags", status_flags, 8'h03);
	end
	endtask
	task s_mask;
	begin
		op(14'h0510, 8'hE0, 8'h00, 1'b0);
		chk("acc", acc, 8'h00);
		chk("flags", status_flags, 8'h07);
		chk("we", file_we, 8'h00);
	end
	endtask
	task s_clear;
	begin
		op(14'h1381, 8'h00, 8'hC7, 1'b1);
		chk("wdata", file_wdata, 8'h47);
		chk("flags", status_flags, 8'h07);
		chk("pre", prescaler_clear, 8'h01);
		chk("addr", file_addr, 8'h01);
		prescaler_to_timer = 1'b0;
		op(14'h1381, 8'h00, 8'hC7, 1'b1);
		chk("pre", prescaler_clear, 8'h00);
		chk("we", file_we, 8'h01);
		prescaler_to_timer = 1'b1;
		op(14'h0581, 8'h3C, 8'h00, 1'b0);
		chk("pre", prescaler_clear, 8'h01);
		chk("wdata", file_wdata, 8'h00);
		chk("acc", acc, 8'h00);
	end
	endtask
	task s_test;
	begin
		op(14'h18A0, 8'h02, 8'h00, 1'b0);
		chk("flags", status_flags, 8'h07);
		op(14'h0710, 8'h01, 8'h00, 1'b0);
		chk("acc", acc, 8'h01);
		op(14'h18A0, 8'h00, 8'h00, 1'b0);
		chk("we", file_we, 8'h00);
		op(14'h0710, 8'h05, 8'h00, 1'b0);
		chk("skip", skip, 8'h01);
		chk("rd", rd_seen, 8'h00);
		chk("acc", acc, 8'h01);
		op(14'h0710, 8'h05, 8'h00, 1'b0);
		chk("acc", acc, 8'h06);
	end
	endtask
	task s_reset;
	begin
		op(14'h18A0, 8'h00, 8'h00, 1'b0);
		reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("acc", acc, 8'h00);
		chk("phase", phase, 8'h00);
		chk("we", file_we, 8'h00);
		chk("done", instr_done, 8'h00);
		reset_n = 1'b1;
		op(14'h0710, 8'h09, 8'h00, 1'b0);
		chk("skip", skip, 8'h00);
		chk("acc", acc, 8'h09);
	end
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		#1 reset_n = 1'b1;
		s_sum;
		s_mask;
		s_clear;
		s_test;
		s_reset;
		test_done;
	end
endmodule // file_register_op_execute_test
